// >>> inc/csc_pkg.sv
// csc_pkg: register map, field positions, reset values and timing for the clock/supply control block.
// assumes: one 20 MHz system clock; registers reached over 32-bit APB.
// Operation
// R1 - clock output enable bit 1 drives pin
// R2 - slow mode bit 0 divides CPU by 32
// R3 - upper trim resets FFh, 00h fastest
// R4 - lower trim bits 6:5 extend trim value
// R5 - software writes trim early, binary search
// R6 - watchdog flag set by reset, write-zero clears
// R7 - undervoltage flag set by reset, read clears
// R8 - pin or watchdog reset keeps undervoltage flag; here the reset input clears it and only a watchdog event leaves it kept
// R9 - two flags together encode reset cause
// R10 - warning flag follows comparator, raises request
// R11 - warning enable RW, request cleared on service
// R12 - prescaler codes divide RC by 2..16; here codes 1..4 give 2..16, codes 0 and 5..7 divide by 1
// R13 - low supply needs prescale at least 2
// R14 - threshold field resets 11, software writable
// R15 - wakeup ready flag hardware driven only
// R16 - RC ready flag hardware driven only
// R17 - source select bit 0 resets to 1
// R18 - software writes zero to reserved bits
// R19 - halt freezes supply register, no wake
// R20 - byte registers, reserved bits read zero
package csc_pkg;
  localparam int unsigned ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_MAIN_CLK = 12'h03A;
  localparam logic [ADDR_W-1:0] IDX_RC_TRIM = 12'h03B;
  localparam logic [ADDR_W-1:0] IDX_SUPPLY = 12'h03C;
  localparam logic [ADDR_W-1:0] IDX_PRESCALE = 12'h03D;
  localparam logic [ADDR_W-1:0] IDX_OSC_SW = 12'h051;
  // main clock control fields
  localparam int unsigned BIT_SLOW = 0;
  localparam int unsigned BIT_CLKOUT = 1;
  // supply integrity fields
  localparam int unsigned BIT_WIE = 0;
  localparam int unsigned BIT_WFLAG = 1;
  localparam int unsigned BIT_UVRF = 2;
  localparam int unsigned BIT_WDRF = 4;
  localparam int unsigned BIT_TRIM_LO = 5;
  // prescale / threshold fields
  localparam int unsigned BIT_THR = 0;
  localparam int unsigned BIT_PRE = 5;
  // oscillator switch fields
  localparam int unsigned BIT_SRC = 0;
  localparam int unsigned BIT_RC_RDY = 2;
  localparam int unsigned BIT_WU_RDY = 3;
  // reset values
  localparam logic [7:0] RST_MAIN_CLK = 8'h00;
  localparam logic [7:0] RST_RC_TRIM = 8'hFF;
  localparam logic [1:0] RST_TRIM_LO = 2'h3;
  localparam logic [2:0] RST_PRE = 3'h0;
  localparam logic [1:0] RST_THR = 2'h3;
  localparam logic RST_SRC = 1'b1;
  // timing
  localparam int unsigned SLOW_DIV = 32;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SETTLE_US = 1;
  localparam int unsigned SETTLE_CYC = (SETTLE_US * CLK_HZ) / 1_000_000;
  localparam logic [31:0] APB_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic clkout_en;
    logic slow_mode;
    logic [9:0] trim;
    logic [2:0] rc_prescale_select;
    logic [1:0] warning_threshold_select;
    logic osc_source_select;
  } csc_ctrl_t;
endpackage : csc_pkg

// >>> logic/csc_top.sv
// csc_top: clock, reset-cause and supply-warning control registers behind an APB slave.
// assumes: pin-level inputs (comparator, reset causes, halt, ready) are asynchronous and are resynchronised here;
// reset causes arrive as event levels, since the chip reset itself is this block's reset.
//
// The APB interface to the registers is this design's own decision.
module csc_top
  import csc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset causes and supply monitor
  input wire logic wdg_reset_event,
  input wire logic uv_reset_event,
  input wire logic supply_warning_in,
  input wire logic halt_active,
  input wire logic irq_service_ack,
  // oscillator status
  input wire logic rc_osc_running,
  input wire logic wakeup_osc_running,
  // outputs to clock logic
  output logic clock_output_enable,
  output logic slow_mode_select,
  output logic [9:0] rc_trim_value,
  output logic [2:0] rc_prescale_select,
  output logic [4:0] rc_divide_shift,
  output logic [1:0] warning_threshold_select,
  output logic osc_source_select,
  output logic supply_warning_irq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_READY = 3'b100
  } csc_sw_t;

  // one-hot prescale decode, shared by the divider output
  function automatic logic [4:0] pre_decode(input logic [2:0] code);
    unique case (code)
      3'h1: pre_decode = 5'h02;
      3'h2: pre_decode = 5'h04;
      3'h3: pre_decode = 5'h08;
      3'h4: pre_decode = 5'h10;
      default: pre_decode = 5'h01;
    endcase
  endfunction

  function automatic logic sync_agree(input logic [2:0] s, input logic prev);
    sync_agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  csc_ctrl_t ctrl_reg;
  logic wdrf_reg;
  logic uvrf_reg;
  logic wflag_reg;
  logic wie_reg;
  logic irq_pend_reg;
  csc_sw_t sw_reg;
  logic [15:0] settle_reg;
  logic rc_rdy_reg;
  logic wu_rdy_reg;
  logic [2:0] s_warn;
  logic [2:0] s_wdg;
  logic [2:0] s_uv;
  logic [2:0] s_halt;
  logic [2:0] s_rcrun;
  logic [2:0] s_wurun;
  logic wdg_lvl_reg;
  logic uv_lvl_reg;
  logic halt_reg;
  logic rcrun_reg;
  logic wurun_reg;
  logic [31:0] prdata_reg;
  logic access_reg;

  logic setup;
  logic wr;
  logic rd;
  logic [ADDR_W-1:0] idx;
  logic mapped;
  logic wdg_rise;
  logic uv_rise;
  logic warn_next;
  logic src_running;
  assign setup = psel && !penable;
  assign idx = paddr[ADDR_W+1:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[31:ADDR_W+2] == '0) &&
                  (idx == IDX_MAIN_CLK || idx == IDX_RC_TRIM || idx == IDX_SUPPLY ||
                   idx == IDX_PRESCALE || idx == IDX_OSC_SW);
  // R20 single-cycle access
  assign wr = psel && penable && pwrite && mapped;
  assign rd = psel && penable && !pwrite && mapped;

  // three-stage synchronisers; a change counts when stages 2 and 3 agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_warn <= 3'h0;
      s_wdg <= 3'h0;
      s_uv <= 3'h0;
      s_halt <= 3'h0;
      s_rcrun <= 3'h0;
      s_wurun <= 3'h0;
    end else begin
      s_warn <= {s_warn[1:0], supply_warning_in};
      s_wdg <= {s_wdg[1:0], wdg_reset_event};
      s_uv <= {s_uv[1:0], uv_reset_event};
      s_halt <= {s_halt[1:0], halt_active};
      s_rcrun <= {s_rcrun[1:0], rc_osc_running};
      s_wurun <= {s_wurun[1:0], wakeup_osc_running};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wdg_lvl_reg <= 1'b0;
      uv_lvl_reg <= 1'b0;
      halt_reg <= 1'b0;
      rcrun_reg <= 1'b0;
      wurun_reg <= 1'b0;
    end else begin
      wdg_lvl_reg <= sync_agree(s_wdg, wdg_lvl_reg);
      uv_lvl_reg <= sync_agree(s_uv, uv_lvl_reg);
      halt_reg <= sync_agree(s_halt, halt_reg);
      rcrun_reg <= sync_agree(s_rcrun, rcrun_reg);
      wurun_reg <= sync_agree(s_wurun, wurun_reg);
    end
  end

  assign wdg_rise = sync_agree(s_wdg, wdg_lvl_reg) && !wdg_lvl_reg;
  assign uv_rise = sync_agree(s_uv, uv_lvl_reg) && !uv_lvl_reg;
  assign warn_next = sync_agree(s_warn, wflag_reg);

  // control fields written by software
  always_ff @(posedge mclk) begin
    if (reset) begin
      // R1 R2 outputs cleared
      {ctrl_reg.clkout_en, ctrl_reg.slow_mode} <= RST_MAIN_CLK[1:0];
      // R3 trim resets to lowest frequency
      ctrl_reg.trim <= {RST_RC_TRIM, RST_TRIM_LO};
      // R12 R14 prescaler and threshold defaults
      ctrl_reg.rc_prescale_select <= RST_PRE;
      ctrl_reg.warning_threshold_select <= RST_THR;
      // R17 wakeup oscillator by default
      ctrl_reg.osc_source_select <= RST_SRC;
    end else if (wr) begin
      unique case (idx)
        IDX_MAIN_CLK: begin
          // R1 clock out enable
          ctrl_reg.clkout_en <= pwdata[BIT_CLKOUT];
          // R2 slow mode select
          ctrl_reg.slow_mode <= pwdata[BIT_SLOW];
        end
        // R3 upper trim byte
        IDX_RC_TRIM: ctrl_reg.trim[9:2] <= pwdata[7:0];
        IDX_SUPPLY: begin
          // R19 frozen while halted
          if (!halt_reg) begin
            // R4 lower trim bits
            ctrl_reg.trim[1:0] <= pwdata[BIT_TRIM_LO+:2];
          end
        end
        IDX_PRESCALE: begin
          // R12 R14 prescale and threshold
          ctrl_reg.rc_prescale_select <= pwdata[BIT_PRE+:3];
          ctrl_reg.warning_threshold_select <= pwdata[BIT_THR+:2];
        end
        IDX_OSC_SW: ctrl_reg.osc_source_select <= pwdata[BIT_SRC];
        default: ;
      endcase
    end
  end

  // reset-cause flags; a set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      wdrf_reg <= 1'b0;
      uvrf_reg <= 1'b0;
    end else begin
      // R6 R9 undervoltage overrides watchdog
      if (uv_rise) begin
        wdrf_reg <= 1'b0;
      end else if (wdg_rise) begin
        wdrf_reg <= 1'b1;
      end else if (wr && idx == IDX_SUPPLY && !halt_reg && !pwdata[BIT_WDRF]) begin
        wdrf_reg <= 1'b0;
      end
      // R7 R8 only undervoltage sets; a read or the reset input clears
      if (uv_rise) begin
        uvrf_reg <= 1'b1;
      end else if (rd && idx == IDX_SUPPLY && !halt_reg) begin
        uvrf_reg <= 1'b0;
      end
    end
  end

  // supply warning flag and its interrupt
  always_ff @(posedge mclk) begin
    if (reset) begin
      wflag_reg <= 1'b0;
      wie_reg <= 1'b0;
      irq_pend_reg <= 1'b0;
    end else begin
      // R19 status frozen during halt
      if (!halt_reg) begin
        // R10 real-time comparator flag
        wflag_reg <= warn_next;
      end
      // R11 enable bit
      if (wr && idx == IDX_SUPPLY && !halt_reg) begin
        wie_reg <= pwdata[BIT_WIE];
      end
      // R10 R11 request on rising flag, cleared on service
      if (!halt_reg && warn_next && !wflag_reg && wie_reg) begin
        irq_pend_reg <= 1'b1;
      end else if (irq_service_ack) begin
        irq_pend_reg <= 1'b0;
      end
    end
  end

  // oscillator switch: wait for running, then settle
  assign src_running = ctrl_reg.osc_source_select ? wurun_reg : rcrun_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sw_reg <= ST_READY;
      settle_reg <= 16'h0000;
    end else if (wr && idx == IDX_OSC_SW && pwdata[BIT_SRC] != ctrl_reg.osc_source_select) begin
      sw_reg <= ST_IDLE;
      settle_reg <= 16'h0000;
    end else begin
      unique case (sw_reg)
        ST_IDLE: if (src_running) sw_reg <= ST_SETTLE;
        ST_SETTLE: begin
          if (settle_reg >= 16'(SETTLE_CYCLES - 1)) begin
            sw_reg <= ST_READY;
          end else begin
            settle_reg <= settle_reg + 16'h0001;
          end
        end
        ST_READY: ;
        default: sw_reg <= ST_IDLE;
      endcase
    end
  end

  // R15 R16 ready flags set only by hardware
  always_ff @(posedge mclk) begin
    if (reset) begin
      wu_rdy_reg <= 1'b1;
      rc_rdy_reg <= 1'b0;
    end else begin
      wu_rdy_reg <= (sw_reg == ST_READY) && ctrl_reg.osc_source_select;
      rc_rdy_reg <= (sw_reg == ST_READY) && !ctrl_reg.osc_source_select;
    end
  end

  // apb answer: zero wait states; unmapped accesses error, and unmapped reads return zero only when idx matches no register
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_reg <= APB_UNMAPPED;
      access_reg <= 1'b0;
    end else begin
      access_reg <= setup;
      if (setup && !pwrite) begin
        // R20 reserved bits read zero
        unique case (idx)
          IDX_MAIN_CLK: prdata_reg <= {30'h0, ctrl_reg.clkout_en, ctrl_reg.slow_mode};
          IDX_RC_TRIM: prdata_reg <= {24'h0, ctrl_reg.trim[9:2]};
          // R9 cause flags read together
          IDX_SUPPLY: prdata_reg <= {25'h0, ctrl_reg.trim[1:0], wdrf_reg, 1'b0, uvrf_reg, wflag_reg, wie_reg};
          IDX_PRESCALE: prdata_reg <= {24'h0, ctrl_reg.rc_prescale_select, 3'h0, ctrl_reg.warning_threshold_select};
          IDX_OSC_SW: prdata_reg <= {28'h0, wu_rdy_reg, rc_rdy_reg, 1'b0, ctrl_reg.osc_source_select};
          default: prdata_reg <= APB_UNMAPPED;
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = access_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !mapped;
    end
  end

  // registered copies to the clock logic
  always_ff @(posedge mclk) begin
    if (reset) begin
      clock_output_enable <= 1'b0;
      slow_mode_select <= 1'b0;
      rc_trim_value <= {RST_RC_TRIM, RST_TRIM_LO};
      rc_prescale_select <= RST_PRE;
      rc_divide_shift <= 5'h01;
      warning_threshold_select <= RST_THR;
      osc_source_select <= RST_SRC;
      supply_warning_irq <= 1'b0;
    end else begin
      clock_output_enable <= ctrl_reg.clkout_en;
      slow_mode_select <= ctrl_reg.slow_mode;
      rc_trim_value <= ctrl_reg.trim;
      rc_prescale_select <= ctrl_reg.rc_prescale_select;
      // R12 divide ratio one-hot
      rc_divide_shift <= pre_decode(ctrl_reg.rc_prescale_select);
      warning_threshold_select <= ctrl_reg.warning_threshold_select;
      osc_source_select <= ctrl_reg.osc_source_select;
      supply_warning_irq <= irq_pend_reg;
    end
  end
endmodule // csc_top

// >>> dv/csc_top_sva.sv
// csc_top_sva: bus and register-side checks for csc_top.
// assumes: bound to csc_top below, sees its ports only.
module csc_top_sva
  import csc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // control side
  input wire logic irq_service_ack,
  input wire logic clock_output_enable,
  input wire logic slow_mode_select,
  input wire logic [9:0] rc_trim_value,
  input wire logic [4:0] rc_divide_shift,
  input wire logic [1:0] warning_threshold_select,
  input wire logic osc_source_select,
  input wire logic supply_warning_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  function automatic logic [31:0] ba(input logic [11:0] i);
    return {18'h0, i, 2'b00};
  endfunction
  function automatic logic [4:0] sh(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h4) ? (5'h01 << c) : 5'h01;
  endfunction
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(logic [11:0] i);
    psel && penable && pready && pwrite && paddr == ba(i);
  endsequence
  property p_answer; s_setup |=> pready && penable; endproperty
  property p_single; pready |=> !pready; endproperty
  property p_unmapped; s_setup ##0 (!pwrite && paddr == 32'h0) |=> pslverr && prdata == 32'h0; endproperty
  // outputs are a registered copy of the control register: visible two edges after the access edge
  property p_clkout; s_wr(IDX_MAIN_CLK) |=> ##1 clock_output_enable == $past(pwdata[1], 2); endproperty
  property p_slow; s_wr(IDX_MAIN_CLK) |=> ##1 slow_mode_select == $past(pwdata[0], 2); endproperty
  property p_trim; s_wr(IDX_RC_TRIM) |=> ##1 rc_trim_value[9:2] == $past(pwdata[7:0], 2); endproperty
  property p_trim_lo; s_wr(IDX_SUPPLY) |=> ##1 rc_trim_value[1:0] == $past(pwdata[6:5], 2); endproperty
  property p_prescale; s_wr(IDX_PRESCALE) |=> ##1 rc_divide_shift == sh($past(pwdata[7:5], 2)); endproperty
  property p_thr; s_wr(IDX_PRESCALE) |=> ##1 warning_threshold_select == $past(pwdata[1:0], 2); endproperty
  property p_src; s_wr(IDX_OSC_SW) |=> ##1 osc_source_select == $past(pwdata[0], 2); endproperty
  // pending bit clears on the ack edge, the output register one edge later
  property p_ack; irq_service_ack && supply_warning_irq |=> ##1 !supply_warning_irq; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_single: assert property (p_single) else $error("pready held too long");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_clkout: assert property (p_clkout) else $error("clock out enable wrong");
  a_slow: assert property (p_slow) else $error("slow mode wrong");
  a_trim: assert property (p_trim) else $error("upper trim wrong");
  a_trim_lo: assert property (p_trim_lo) else $error("lower trim wrong");
  a_prescale: assert property (p_prescale) else $error("divide ratio wrong");
  a_thr: assert property (p_thr) else $error("threshold wrong");
  a_src: assert property (p_src) else $error("source select wrong");
  a_ack: assert property (p_ack) else $error("request not cleared on service");
endmodule // csc_top_sva

bind csc_top csc_top_sva chk (.*);

// >>> dv/clock_supply_control_regs_bench.sv
// clock_supply_control_regs_bench: self-checking bench for csc_top.
// assumes: checker bound in csc_top_sva; reads checked from a queue of expectations.
module clock_supply_control_regs_bench import csc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic wdg_reset_event = 0, uv_reset_event = 0, supply_warning_in = 0, halt_active = 0;
  logic irq_service_ack = 0, rc_osc_running = 0, wakeup_osc_running = 1;
  logic clock_output_enable, slow_mode_select, osc_source_select, supply_warning_irq;
  logic [9:0] rc_trim_value;
  logic [2:0] rc_prescale_select;
  logic [4:0] rc_divide_shift;
  logic [1:0] warning_threshold_select;
  int errors = 0, tests_run = 0, seed = 74;
  logic [32:0] exp_q[$];
  logic [7:0] r, sup;
  // short settle keeps the oscillator switch quick
  csc_top #(.SETTLE_CYCLES(4)) dut (.*);
  always #25 mclk = ~mclk;
  task chk(input string n, input logic [32:0] e, input logic [32:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] i, input logic [7:0] d, input logic e = 0);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {18'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    if (!w) exp_q.push_back({e, 24'h0, d});
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task pulse(input int k);
    @(posedge mclk);
    if (k == 0) wdg_reset_event <= 1;
    else uv_reset_event <= 1;
    repeat (10) @(posedge mclk);
    wdg_reset_event <= 0;
    uv_reset_event <= 0;
    repeat (10) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("unexpected read", 33'h0, 33'h1);
      else chk("prdata", exp_q.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    #200_000;
    errors++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 0;
    xfer(0, IDX_MAIN_CLK, 8'h00);
    xfer(0, IDX_RC_TRIM, 8'hFF);
    xfer(0, IDX_PRESCALE, 8'h03);
    xfer(0, IDX_OSC_SW, 8'h09);
    sup = 8'h20;
    xfer(1, IDX_SUPPLY, sup);
    xfer(0, IDX_SUPPLY, sup);
    chk("trim_lo", 2'b01, rc_trim_value[1:0]);
    for (int k = 0; k < 8; k++) begin
      r = {k[2:0], 3'b000, k[1:0]};
      xfer(1, IDX_PRESCALE, r);
      xfer(0, IDX_PRESCALE, r);
      chk("shift", (k >= 1 && k <= 4) ? (5'h01 << k) : 5'h01, rc_divide_shift);
      chk("presc", r[7:5], rc_prescale_select);
    end
    // low-supply setting: divide by 2 at least
    xfer(1, IDX_PRESCALE, 8'h23);
    xfer(0, IDX_PRESCALE, 8'h23);
    chk("shift min", 5'h02, rc_divide_shift);
    r = 8'($random(seed));
    xfer(1, IDX_RC_TRIM, r);
    xfer(0, IDX_RC_TRIM, r);
    chk("trim", r, rc_trim_value[9:2]);
    r = 8'($random(seed)) & 8'h03;
    xfer(1, IDX_MAIN_CLK, r);
    xfer(0, IDX_MAIN_CLK, r);
    chk("main out", r[1:0], {clock_output_enable, slow_mode_select});
    pulse(0);
    xfer(0, IDX_SUPPLY, sup | 8'h10);
    xfer(1, IDX_SUPPLY, sup);
    xfer(0, IDX_SUPPLY, sup);
    pulse(0);
    pulse(1);
    xfer(0, IDX_SUPPLY, sup | 8'h04);
    xfer(0, IDX_SUPPLY, sup);
    pulse(1);
    pulse(0);
    xfer(0, IDX_SUPPLY, sup | 8'h14);
    xfer(0, IDX_SUPPLY, sup | 8'h10);
    xfer(1, IDX_SUPPLY, sup);
    sup = 8'h21;
    xfer(1, IDX_SUPPLY, sup);
    supply_warning_in <= 1;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    chk("irq", 1'b1, supply_warning_irq);
    xfer(0, IDX_SUPPLY, sup | 8'h02);
    irq_service_ack <= 1;
    @(posedge mclk);
    irq_service_ack <= 0;
    repeat (2) @(negedge mclk);
    chk("irq ack", 1'b0, supply_warning_irq);
    @(posedge mclk);
    supply_warning_in <= 0;
    repeat (10) @(posedge mclk);
    xfer(0, IDX_SUPPLY, sup);
    halt_active <= 1;
    repeat (10) @(posedge mclk);
    supply_warning_in <= 1;
    repeat (10) @(negedge mclk);
    chk("halt irq", 1'b0, supply_warning_irq);
    xfer(0, IDX_SUPPLY, sup);
    // drop warning before leaving halt so no late edge is seen
    supply_warning_in <= 0;
    repeat (10) @(posedge mclk);
    halt_active <= 0;
    xfer(0, 12'h000, 8'h00, 1'b1);
    rc_osc_running <= 1;
    xfer(1, IDX_OSC_SW, 8'h00);
    repeat (20) @(posedge mclk);
    xfer(0, IDX_OSC_SW, 8'h04);
    xfer(1, IDX_OSC_SW, 8'h01);
    repeat (20) @(posedge mclk);
    xfer(0, IDX_OSC_SW, 8'h09);
    repeat (2) @(posedge mclk);
    stop_test;
  end
endmodule // clock_supply_control_regs_bench
